// [rtl/cpab_cfg.svh]
`ifndef CPAB_CFG_SVH
`define CPAB_CFG_SVH
// Opcode field values of the instruction word
`define CPAB_OP_ADD    6'h00
`define CPAB_OP_ADC    6'h01
`define CPAB_OP_SUB    6'h02
`define CPAB_OP_SUBTRACT_IMMEDIATE   6'h03
`define CPAB_OP_SBCR   6'h04
`define CPAB_OP_SBCK   6'h05
`define CPAB_OP_AND    6'h06
`define CPAB_OP_AND_IMMEDIATE   6'h07
`define CPAB_OP_OR     6'h08
`define CPAB_OP_ORI    6'h09
`define CPAB_OP_XOR    6'h0a
`define CPAB_OP_SETM   6'h0b
`define CPAB_OP_CLRM   6'h0c
`define CPAB_OP_TEST   6'h0d
`define CPAB_OP_ADDW   6'h0e
`define CPAB_OP_SUBW   6'h0f
`define CPAB_OP_CMP    6'h10
`define CPAB_OP_CMPC   6'h11
`define CPAB_OP_CMPI   6'h12
`define CPAB_OP_CSKEQ  6'h13
`define CPAB_OP_SKRC   6'h14
`define CPAB_OP_SKRS   6'h15
`define CPAB_OP_SKIC   6'h16
`define CPAB_OP_SKIS   6'h17
`define CPAB_OP_RJUMP  6'h18
`define CPAB_OP_RELATIVE_CALL  6'h19
`define CPAB_OP_PJUMP  6'h1a
`define CPAB_OP_PCALL  6'h1b
`define CPAB_OP_BFSET  6'h1c
`define CPAB_OP_BFCLR  6'h1d
`define CPAB_OP_IOSET  6'h1e
`define CPAB_OP_IOCLR  6'h1f
`define CPAB_OP_BSGE   6'h20
`define CPAB_OP_BSLT   6'h21
// Cycle counts per instruction class
`define CPAB_CYC_BASIC  2'h1
`define CPAB_CYC_WORD   2'h2
`define CPAB_CYC_JUMP   2'h2
`define CPAB_CYC_CALL   2'h3
`define CPAB_CYC_BRANCH 2'h2
`define CPAB_CYC_IOBIT  2'h2
`define CPAB_CNT_LAST   2'h1
// Program counter steps
`define CPAB_STEP_SHORT 2'h1
`define CPAB_STEP_LONG  2'h2
// Pointer pair and masks
`define CPAB_ZL_IDX     5'h1e
`define CPAB_ZH_IDX     5'h1f
`define CPAB_BYTE_ONES  8'hff
// Register map
`define CPAB_ADDR_CTRL   8'h00
`define CPAB_ADDR_STATUS 8'h04
`define CPAB_ADDR_PC     8'h08
`define CPAB_ADDR_SP     8'h0c
`define CPAB_CTRL_RUN    0
`define CPAB_RUN_RESET   1'h0
`define CPAB_FLAGS_RESET 8'h00
`define CPAB_RESP_OKAY   2'h0
`define CPAB_RESP_SLVERR 2'h2
`endif

// [rtl/cpab_pkg.sv]
package cpab_pkg;
  typedef struct packed {
    logic       tw;
    logic [5:0] op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [7:0] imm;
  } cpab_instr_t;
  typedef struct packed {
    logic i, t, h, s, v, n, z, c;
  } cpab_flags_t;
  typedef struct packed {
    logic       stb;
    logic [4:0] addr;
    logic [2:0] bit_sel;
    logic       val;
  } cpab_iowr_t;
  typedef enum logic [2:0] {CPAB_ALU_ADD, CPAB_ALU_SUB, CPAB_ALU_AND, CPAB_ALU_OR,
                            CPAB_ALU_XOR} cpab_alu_t;
  typedef enum logic [1:0] {CPAB_ST_EXEC, CPAB_ST_STALL, CPAB_ST_SKIP} cpab_state_t;
endpackage

// [rtl/cpab_alu.sv]
module cpab_alu
  import cpab_pkg::*;
(
  // Operation
  input  cpab_alu_t   kind,
  input  logic        use_carry,
  input  logic        chain_z,
  // Operands and flags
  input  logic [7:0]  a,
  input  logic [7:0]  b,
  input  cpab_flags_t flags_in,
  // Result
  output logic [7:0]  res,
  output cpab_flags_t flags_out
);
  function automatic logic carry_out(input logic x, input logic y, input logic r,
                                     input logic sub);
    carry_out = sub ? ((!x & y) | (y & r) | (r & !x)) : ((x & y) | (y & !r) | (!r & x));
  endfunction

  function automatic logic ovf(input logic x, input logic y, input logic r, input logic sub);
    ovf = sub ? ((x & !y & !r) | (!x & y & r)) : ((x & y & !r) | (!x & !y & r));
  endfunction

  wire       cin    = use_carry & flags_in.c;
  wire       is_sub = kind == CPAB_ALU_SUB;
  wire       arith  = (kind == CPAB_ALU_ADD) || is_sub;
  wire [7:0] sum    = 8'(a + b + {7'h00, cin});
  wire [7:0] dif    = 8'(a - b - {7'h00, cin});
  wire       zero   = res == 8'h00;

  always_comb begin
    case (kind)
      CPAB_ALU_ADD: res = sum;
      CPAB_ALU_SUB: res = dif;
      CPAB_ALU_AND: res = a & b;
      CPAB_ALU_OR:  res = a | b;
      CPAB_ALU_XOR: res = a ^ b;
      default:      res = a;
    endcase
  end

  // Logic ops touch Z, N, V only; arithmetic adds C and H
  always_comb begin
    flags_out   = flags_in;
    flags_out.n = res[7];
    flags_out.z = chain_z ? (zero & flags_in.z) : zero;
    flags_out.v = arith & ovf(a[7], b[7], res[7], is_sub);
    if (arith) begin
      flags_out.c = carry_out(a[7], b[7], res[7], is_sub);
      flags_out.h = carry_out(a[3], b[3], res[3], is_sub);
    end
  end
endmodule  // cpab_alu

// [rtl/cpab_cond.sv]
`include "cpab_cfg.svh"
module cpab_cond
  import cpab_pkg::*;
(
  // Instruction fields
  input  logic [5:0]  op,
  input  logic [2:0]  sel,
  // Tested state
  input  cpab_flags_t flags,
  input  logic [7:0]  rd_v,
  input  logic [7:0]  rr_v,
  input  logic        io_bit,
  // Decision
  output logic        take
);
  wire [7:0] fvec    = flags;
  wire       reg_bit = rr_v[sel];

  always_comb begin
    case (op)
      `CPAB_OP_CSKEQ: take = rd_v == rr_v;
      `CPAB_OP_SKRC:  take = !reg_bit;
      `CPAB_OP_SKRS:  take = reg_bit;
      `CPAB_OP_SKIC:  take = !io_bit;
      `CPAB_OP_SKIS:  take = io_bit;
      `CPAB_OP_BFSET: take = fvec[sel];
      `CPAB_OP_BFCLR: take = !fvec[sel];
      `CPAB_OP_BSGE:  take = !(flags.n ^ flags.v);
      `CPAB_OP_BSLT:  take = flags.n ^ flags.v;
      default:        take = 1'b0;
    endcase
  end
endmodule  // cpab_cond

// [rtl/cpab_core.sv]
// Chosen here: the register offsets and the AXI4-Lite register port.
`include "cpab_cfg.svh"
module cpab_core
  import cpab_pkg::*;
#(
  parameter int PC_W    = 12,
  parameter int STACK_D = 8,
  parameter int SP_W    = 3
) (
  // Clock, reset, clock enable
  input  logic              aclk,
  input  logic              aresetn,
  input  logic              ce,
  // AXI4-Lite write address
  input  logic              awvalid,
  output logic              awready,
  input  logic [7:0]        awaddr,
  // AXI4-Lite write data
  input  logic              wvalid,
  output logic              wready,
  input  logic [31:0]       wdata,
  input  logic [3:0]        wstrb,
  // AXI4-Lite write response
  output logic              bvalid,
  input  logic              bready,
  output logic [1:0]        bresp,
  // AXI4-Lite read address
  input  logic              arvalid,
  output logic              arready,
  input  logic [7:0]        araddr,
  // AXI4-Lite read data
  output logic              rvalid,
  input  logic              rready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  // Program memory
  output logic [PC_W-1:0]   imem_addr,
  input  cpab_instr_t       imem_data,
  // Low I/O registers
  input  logic [255:0]      io_view,
  output cpab_iowr_t        io_wr,
  // Status
  output logic              retire
);
  cpab_instr_t      ins;
  cpab_state_t      st;
  cpab_state_t      next_st;
  cpab_flags_t      flags;
  cpab_flags_t      alu_flags;
  cpab_flags_t      w_flags;
  cpab_alu_t        alu_kind;
  logic [7:0]       regs [32];
  logic [PC_W-1:0]  stk [STACK_D];
  logic [PC_W-1:0]  pc;
  logic [PC_W-1:0]  next_pc;
  logic [SP_W-1:0]  sp;
  logic [1:0]       cnt;
  logic [1:0]       next_cnt;
  logic [1:0]       ex_cyc;
  logic             run;
  logic [7:0]       alu_res;
  logic             take;
  logic             aw_have;
  logic             w_have;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data;
  logic             w_lane0;
  logic [31:0]      rd_word;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `CPAB_ADDR_CTRL) || (a == `CPAB_ADDR_STATUS) ||
             (a == `CPAB_ADDR_PC) || (a == `CPAB_ADDR_SP);
  endfunction

  function automatic logic [PC_W-1:0] rel_tgt(input logic [PC_W-1:0] p, input logic [11:0] k);
    rel_tgt = p + PC_W'($signed(k)) + PC_W'(1'b1);
  endfunction

  // Instruction decode
  assign ins = imem_data;
  wire [5:0]      op      = ins.op;
  wire            go      = (st == CPAB_ST_EXEC) && run;
  wire [4:0]      rd_hi   = ins.rd + 5'h01;
  wire [7:0]      rd_v    = regs[ins.rd];
  wire [7:0]      rr_v    = regs[ins.rr];
  wire [11:0]     offs    = {ins.rr[3:0], ins.imm};
  wire [15:0]     z_ptr   = {regs[`CPAB_ZH_IDX], regs[`CPAB_ZL_IDX]};
  wire [7:0]      io_idx  = {ins.rr, ins.rd[2:0]};
  wire [PC_W-1:0] rel_pc  = rel_tgt(pc, offs);
  wire [PC_W-1:0] pc_inc  = pc + PC_W'(`CPAB_STEP_SHORT);
  wire op_imm   = (op == `CPAB_OP_SUBTRACT_IMMEDIATE) || (op == `CPAB_OP_SBCK) || (op == `CPAB_OP_AND_IMMEDIATE) ||
                  (op == `CPAB_OP_ORI) || (op == `CPAB_OP_SETM) || (op == `CPAB_OP_CMPI);
  wire op_sub   = (op == `CPAB_OP_SUB) || (op == `CPAB_OP_SUBTRACT_IMMEDIATE) || (op == `CPAB_OP_SBCR) ||
                  (op == `CPAB_OP_SBCK);
  wire op_cmp   = (op == `CPAB_OP_CMP) || (op == `CPAB_OP_CMPC) || (op == `CPAB_OP_CMPI);
  wire op_and   = (op == `CPAB_OP_AND) || (op == `CPAB_OP_AND_IMMEDIATE) || (op == `CPAB_OP_CLRM) ||
                  (op == `CPAB_OP_TEST);
  wire op_or    = (op == `CPAB_OP_OR) || (op == `CPAB_OP_ORI) || (op == `CPAB_OP_SETM);
  wire op_add   = (op == `CPAB_OP_ADD) || (op == `CPAB_OP_ADC);
  wire op_xor   = op == `CPAB_OP_XOR;
  wire op_word  = (op == `CPAB_OP_ADDW) || (op == `CPAB_OP_SUBW);
  wire op_call  = (op == `CPAB_OP_RELATIVE_CALL) || (op == `CPAB_OP_PCALL);
  wire op_rel   = (op == `CPAB_OP_RJUMP) || (op == `CPAB_OP_RELATIVE_CALL);
  wire op_ptr   = (op == `CPAB_OP_PJUMP) || (op == `CPAB_OP_PCALL);
  wire op_iobit = (op == `CPAB_OP_IOSET) || (op == `CPAB_OP_IOCLR);
  wire op_skip  = (op >= `CPAB_OP_CSKEQ) && (op <= `CPAB_OP_SKIS);
  wire op_br    = (op == `CPAB_OP_BFSET) || (op == `CPAB_OP_BFCLR) ||
                  (op == `CPAB_OP_BSGE) || (op == `CPAB_OP_BSLT);
  wire alu_upd  = op_add || op_sub || op_cmp || op_and || op_or || op_xor;
  wire alu_wr   = alu_upd && !op_cmp && (op != `CPAB_OP_TEST);
  wire use_c    = (op == `CPAB_OP_ADC) || (op == `CPAB_OP_SBCR) || (op == `CPAB_OP_SBCK) ||
                  (op == `CPAB_OP_CMPC);
  // Test feeds the register to both sides, clear-mask inverts the constant
  wire [7:0] opb = (op == `CPAB_OP_TEST) ? rd_v :
                   (op == `CPAB_OP_CLRM) ? (`CPAB_BYTE_ONES - ins.imm) :
                   op_imm ? ins.imm : rr_v;

  assign alu_kind = (op_sub || op_cmp) ? CPAB_ALU_SUB :
                    op_and ? CPAB_ALU_AND :
                    op_or  ? CPAB_ALU_OR  :
                    op_xor ? CPAB_ALU_XOR : CPAB_ALU_ADD;

  cpab_alu u_alu (
    .kind      (alu_kind),
    .use_carry (use_c),
    .chain_z   (use_c && !op_add),
    .a         (rd_v),
    .b         (opb),
    .flags_in  (flags),
    .res       (alu_res),
    .flags_out (alu_flags)
  );

  cpab_cond u_cond (
    .op     (op),
    .sel    (ins.rd[2:0]),
    .flags  (flags),
    .rd_v   (rd_v),
    .rr_v   (rr_v),
    .io_bit (io_view[io_idx]),
    .take   (take)
  );

  // Word arithmetic on the register pair
  wire        w_sub = op == `CPAB_OP_SUBW;
  wire [15:0] w_in  = {regs[rd_hi], rd_v};
  wire [15:0] w_res = w_sub ? (w_in - {8'h00, ins.imm}) : (w_in + {8'h00, ins.imm});
  always_comb begin
    w_flags   = flags;
    w_flags.n = w_res[15];
    w_flags.z = w_res == 16'h0000;
    w_flags.v = w_sub ? (w_in[15] & !w_res[15]) : (!w_in[15] & w_res[15]);
    w_flags.c = w_sub ? (w_res[15] & !w_in[15]) : (!w_res[15] & w_in[15]);
    w_flags.s = w_flags.n ^ w_flags.v;
  end

  // Cycle cost of the instruction in execute
  always_comb begin
    if (op_word)
      ex_cyc = `CPAB_CYC_WORD;
    else if (op_call)
      ex_cyc = `CPAB_CYC_CALL;
    else if ((op == `CPAB_OP_RJUMP) || (op == `CPAB_OP_PJUMP))
      ex_cyc = `CPAB_CYC_JUMP;
    else if (op_iobit)
      ex_cyc = `CPAB_CYC_IOBIT;
    else if (op_br && take)
      ex_cyc = `CPAB_CYC_BRANCH;
    else
      ex_cyc = `CPAB_CYC_BASIC;
  end

  // Sequencer
  always_comb begin
    next_pc  = pc;
    next_st  = st;
    next_cnt = cnt;
    case (st)
      CPAB_ST_EXEC: begin
        if (run) begin
          next_pc = pc_inc;
          if (op_rel || (op_br && take))
            next_pc = rel_pc;
          else if (op_ptr)
            next_pc = z_ptr[PC_W-1:0];
          if (op_skip && take) begin
            next_st = CPAB_ST_SKIP;
          end else if (ex_cyc != `CPAB_CYC_BASIC) begin
            next_st  = CPAB_ST_STALL;
            next_cnt = ex_cyc - `CPAB_CNT_LAST;
          end
        end
      end
      CPAB_ST_STALL: begin
        next_cnt = cnt - `CPAB_CNT_LAST;
        if (cnt == `CPAB_CNT_LAST)
          next_st = CPAB_ST_EXEC;
      end
      CPAB_ST_SKIP: begin
        // The fetched word is the one skipped; its length sets the step
        next_pc  = pc + (ins.tw ? PC_W'(`CPAB_STEP_LONG) : PC_W'(`CPAB_STEP_SHORT));
        next_st  = ins.tw ? CPAB_ST_STALL : CPAB_ST_EXEC;
        next_cnt = `CPAB_CNT_LAST;
      end
      default: begin
        next_st = CPAB_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st     <= CPAB_ST_EXEC;
      pc     <= '0;
      cnt    <= '0;
      retire <= 1'b0;
    end else if (ce) begin
      st     <= next_st;
      pc     <= next_pc;
      cnt    <= next_cnt;
      retire <= ((st != CPAB_ST_EXEC) || run) && (next_st == CPAB_ST_EXEC);
    end
  end

  // Register file and return stack
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 32; i++)
        regs[i] <= 8'h00;
      sp <= '0;
    end else if (ce && go) begin
      if (alu_wr)
        regs[ins.rd] <= alu_res;
      if (op_word) begin
        regs[ins.rd] <= w_res[7:0];
        regs[rd_hi]  <= w_res[15:8];
      end
      if (op_call) begin
        stk[sp] <= pc_inc;
        sp      <= sp + SP_W'(1'b1);
      end
    end
  end

  // Status flags: an executing instruction wins over a bus write
  wire wr_fire   = aw_have && w_have && !bvalid;
  wire wr_ctrl   = wr_fire && w_lane0 && (aw_addr == `CPAB_ADDR_CTRL);
  wire wr_status = wr_fire && w_lane0 && (aw_addr == `CPAB_ADDR_STATUS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= `CPAB_FLAGS_RESET;
      run   <= `CPAB_RUN_RESET;
    end else if (ce) begin
      if (go && alu_upd)
        flags <= alu_flags;
      else if (go && op_word)
        flags <= w_flags;
      else if (wr_status)
        flags <= w_data[7:0];
      if (wr_ctrl)
        run <= w_data[`CPAB_CTRL_RUN];
    end
  end

  // Single-bit I/O write, applied by the register owner to one bit only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_wr <= '0;
    end else if (ce) begin
      io_wr.stb     <= go && op_iobit;
      io_wr.addr    <= ins.rr;
      io_wr.bit_sel <= ins.rd[2:0];
      io_wr.val     <= op == `CPAB_OP_IOSET;
    end
  end
  assign imem_addr = pc;

  // AXI4-Lite slave
  assign awready = !aw_have && !bvalid;
  assign wready  = !w_have && !bvalid;
  assign arready = !rvalid;
  always_comb begin
    case (araddr)
      `CPAB_ADDR_CTRL:   rd_word = {31'h0, run};
      `CPAB_ADDR_STATUS: rd_word = {24'h0, flags};
      `CPAB_ADDR_PC:     rd_word = 32'(pc);
      `CPAB_ADDR_SP:     rd_word = 32'(sp);
      default:           rd_word = 32'h0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_lane0 <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `CPAB_RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `CPAB_RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_have <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_have  <= 1'b1;
        w_data  <= wdata;
        w_lane0 <= wstrb[0];
      end
      if (wr_fire) begin
        aw_have <= 1'b0;
        w_have  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= mapped(aw_addr) ? `CPAB_RESP_OKAY : `CPAB_RESP_SLVERR;
      end else if (bready) begin
        bvalid  <= 1'b0;
      end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_word;
        rresp  <= mapped(araddr) ? `CPAB_RESP_OKAY : `CPAB_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk iff ce); endclocking
  default disable iff (!aresetn);

  sequence s_stall_one;
    (st == CPAB_ST_STALL) ##1 (st == CPAB_ST_EXEC);
  endsequence
  sequence s_stall_two;
    (st == CPAB_ST_STALL) [*2] ##1 (st == CPAB_ST_EXEC);
  endsequence

  a_add_sum_store: assert property (go && (op == `CPAB_OP_ADD) && !ins.tw |=>
    regs[$past(ins.rd)] == 8'($past(rd_v) + $past(rr_v)))
    else $error("add result not stored");
  a_word_two_cyc: assert property (go && op_word |=> s_stall_one)
    else $error("word op not two cycles");
  a_sub_borrow_flag: assert property (go && op_sub && !use_c |=>
    flags.c == ($past(opb) > $past(rd_v)))
    else $error("subtract borrow wrong");
  a_logic_flags_kept: assert property (go && (op_and || op_or || op_xor) |=>
    !flags.v && (flags.c == $past(flags.c)) && (flags.h == $past(flags.h)))
    else $error("logic op touched wrong flags");
  a_clear_mask_val: assert property (go && (op == `CPAB_OP_CLRM) |=>
    regs[$past(ins.rd)] == ($past(rd_v) & ~$past(ins.imm)))
    else $error("clear mask result wrong");
  a_relative_call_timing: assert property (go && (op == `CPAB_OP_RELATIVE_CALL) |=>
    (pc == $past(rel_pc)) ##0 s_stall_two)
    else $error("relative call target or timing wrong");
  a_ptr_jump_z: assert property (go && (op == `CPAB_OP_PJUMP) |=>
    (pc == $past(z_ptr[PC_W-1:0])) ##0 s_stall_one)
    else $error("pointer jump wrong");
  a_skip_advance: assert property (go && op_skip && take |=>
    (st == CPAB_ST_SKIP) ##1
    (pc == $past(pc, 2) + ($past(ins.tw) ? PC_W'(2'h3) : PC_W'(2'h2))))
    else $error("skip advance wrong");
  a_branch_untaken: assert property (go && op_br && !take |=>
    (st == CPAB_ST_EXEC) && (pc == $past(pc_inc)))
    else $error("untaken branch wrong");
  a_signed_ge_take: assert property (go && (op == `CPAB_OP_BSGE) && !(flags.n ^ flags.v) |=>
    pc == $past(rel_pc))
    else $error("signed branch not taken");
  a_iobit_write: assert property (go && (op == `CPAB_OP_IOSET) |=>
    io_wr.stb && io_wr.val && (io_wr.addr == $past(ins.rr)) && (flags == $past(flags)))
    else $error("io bit set wrong");
endmodule  // cpab_core

// [tb/cpab_imem.sv]
module cpab_imem
  import cpab_pkg::*;
#(
  parameter int PC_W = 12
) (
  // Fetch port
  input  wire logic [PC_W-1:0] addr,
  output cpab_instr_t          data
);
  timeunit 1ns;
  timeprecision 1ns;
  cpab_instr_t prog [2**PC_W];
  // Word is valid in the same cycle as its address
  assign data = prog[addr];
endmodule // cpab_imem

// [tb/tb_top.sv]
`include "cpab_cfg.svh"
module tb_top
  import cpab_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          aclk = 0, aresetn = 0, ce = 1;
  logic          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]    awaddr = 0, araddr = 0;
  logic [31:0]   wdata = 0;
  logic [255:0]  io_view = 256'h2_0000;
  logic          awready, wready, bvalid, arready, rvalid, retire;
  logic [1:0]    bresp, rresp, r;
  logic [31:0]   rdata, d;
  logic [11:0]   imem_addr;
  cpab_instr_t   imem_data;
  cpab_iowr_t    io_wr;
  int            num_errors = 0, compares = 0, io_n = 0, ret_n = 0;
  logic [8:0]    io_last = 0;
  // Jump to itself parks the core
  localparam cpab_instr_t HALT = {1'b0, `CPAB_OP_RJUMP, 5'h00, 5'h0f, 8'hff};

  cpab_core dut (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb(4'h1), .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .imem_addr, .imem_data, .io_view,
    .io_wr, .retire);
  cpab_imem #(.PC_W(12)) mem (.addr(imem_addr), .data(imem_data));

  always #50 aclk = ~aclk;

  always @(posedge aclk) begin
    if (io_wr.stb === 1'b1) begin
      io_n <= io_n + 1;
      io_last <= {io_wr.addr, io_wr.bit_sel, io_wr.val};
    end
    if (ce && retire === 1'b1)
      ret_n <= ret_n + 1;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    bit ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end while (!(ta && tw));
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  function automatic cpab_instr_t ins(logic [5:0] op, logic [4:0] rd_i, logic [4:0] rr_i,
                                      logic [7:0] imm);
    return {1'b0, op, rd_i, rr_i, imm};
  endfunction

  task automatic rst();
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic clear();
    foreach (mem.prog[i]) mem.prog[i] = HALT;
  endtask

  // Reset, start the core, let the program park, then read its state
  task automatic go(input logic [31:0] pc, input logic [31:0] st, input logic [31:0] sp);
    int k;
    rst();
    wr(`CPAB_ADDR_CTRL, 32'h1, r);
    // Frozen right after the first execute cycle, with the pc already stepped to 1
    ce <= 1'b0;
    repeat (20) @(posedge aclk);
    check("frozen pc", imem_addr, 32'h1);
    ce <= 1'b1;
    repeat (40) @(posedge aclk);
    rd(`CPAB_ADDR_PC, d, r);
    check("pc", d, pc);
    rd(`CPAB_ADDR_STATUS, d, r);
    check("status", d, st);
    rd(`CPAB_ADDR_SP, d, r);
    check("sp", d, sp);
    // Parked on a jump to itself: one retire every two cycles
    k = ret_n;
    repeat (20) @(posedge aclk);
    check("retire", ret_n - k, 32'ha);
  endtask

  initial begin
    repeat (2000) @(posedge aclk);
    num_errors++;
    wrap_up();
  end

  initial begin
    clear();
    rst();
    rd(`CPAB_ADDR_STATUS, d, r);
    check("status reset", d, 32'h0);
    wr(`CPAB_ADDR_STATUS, 32'h80, r);
    rd(`CPAB_ADDR_STATUS, d, r);
    check("status rw", d, 32'h80);
    wr(`CPAB_ADDR_PC, 32'h55, r);
    check("pc wr resp", r, 32'h0);
    rd(`CPAB_ADDR_PC, d, r);
    check("pc ro", d, 32'h0);
    wr(8'h10, 32'h1, r);
    check("unmapped wr", r, 32'h2);
    rd(8'h10, d, r);
    check("unmapped rd", {d[29:0], r}, 32'h2);
    // Flags: 0-1, pair 0-1, mask clear, AND with zero, signed branch
    clear();
    mem.prog[0] = ins(`CPAB_OP_SUBTRACT_IMMEDIATE, 5'h10, 5'h00, 8'h01);
    mem.prog[1] = ins(`CPAB_OP_SUBW, 5'h18, 5'h00, 8'h01);
    mem.prog[2] = ins(`CPAB_OP_CLRM, 5'h10, 5'h00, 8'h0f);
    mem.prog[3] = ins(`CPAB_OP_AND, 5'h10, 5'h00, 8'h00);
    mem.prog[4] = ins(`CPAB_OP_BSGE, 5'h00, 5'h00, 8'h01);
    go(6, 32'h33, 0);
    // Taken flag branch on C, signed less-than, untaken branch
    clear();
    mem.prog[0] = ins(`CPAB_OP_SUBTRACT_IMMEDIATE, 5'h10, 5'h00, 8'h01);
    mem.prog[1] = ins(`CPAB_OP_BFSET, 5'h00, 5'h00, 8'h01);
    mem.prog[3] = ins(`CPAB_OP_BSLT, 5'h00, 5'h00, 8'h01);
    mem.prog[5] = ins(`CPAB_OP_BFCLR, 5'h00, 5'h00, 8'h04);
    go(6, 32'h25, 0);
    // Skips over a two-word and a one-word instruction, then I/O bit writes
    clear();
    mem.prog[0] = ins(`CPAB_OP_CSKEQ, 5'h00, 5'h01, 8'h00);
    mem.prog[1] = ins(`CPAB_OP_ADD, 5'h02, 5'h02, 8'h00);
    mem.prog[1].tw = 1'b1;
    mem.prog[3] = ins(`CPAB_OP_SKIS, 5'h01, 5'h02, 8'h00);
    mem.prog[5] = ins(`CPAB_OP_IOSET, 5'h03, 5'h05, 8'h00);
    mem.prog[6] = ins(`CPAB_OP_IOCLR, 5'h07, 5'h1f, 8'h00);
    mem.prog[7] = ins(`CPAB_OP_ADD, 5'h00, 5'h00, 8'h00);
    go(8, 32'h2, 0);
    check("io writes", io_n, 2);
    check("io last", io_last, {5'h1f, 3'h7, 1'b0});
    // Pointer jump through Z, then relative call
    clear();
    mem.prog[0] = ins(`CPAB_OP_SUBTRACT_IMMEDIATE, 5'h1e, 5'h00, 8'hf9);
    mem.prog[1] = ins(`CPAB_OP_PJUMP, 5'h00, 5'h00, 8'h00);
    mem.prog[7] = ins(`CPAB_OP_RELATIVE_CALL, 5'h00, 5'h00, 8'h02);
    go(10, 32'h21, 1);
    // Immediate logic, compares, register-bit skip, carry chain, branch on H
    clear();
    mem.prog[0] = ins(`CPAB_OP_ORI, 5'h10, 5'h00, 8'h80);
    mem.prog[1] = ins(`CPAB_OP_SETM, 5'h11, 5'h00, 8'h01);
    mem.prog[2] = ins(`CPAB_OP_CMPI, 5'h10, 5'h00, 8'h80);
    mem.prog[3] = ins(`CPAB_OP_XOR, 5'h11, 5'h10, 8'h00);
    mem.prog[4] = ins(`CPAB_OP_TEST, 5'h11, 5'h00, 8'h00);
    mem.prog[5] = ins(`CPAB_OP_SKRS, 5'h00, 5'h11, 8'h00);
    mem.prog[7] = ins(`CPAB_OP_ADC, 5'h10, 5'h11, 8'h00);
    mem.prog[8] = ins(`CPAB_OP_CMPC, 5'h10, 5'h11, 8'h00);
    mem.prog[9] = ins(`CPAB_OP_BFSET, 5'h05, 5'h00, 8'h01);
    go(11, 32'h21, 0);
    wrap_up();
  end
endmodule // tb_top
